// ---- rtl/amc_pkg.sv ----
package amc_pkg;
    localparam logic [15:0] ADDR_OUT_SELECT = 16'hFFE1;
    localparam logic [15:0] ADDR_PRIMARY_DIV = 16'hFFE2;
    localparam logic [15:0] ADDR_SECONDARY_DIV = 16'hFFF6;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // writable bit masks; clear bits are reserved and read zero
    localparam logic [7:0] MASK_OUT_SELECT = 8'hDF;
    localparam logic [7:0] MASK_PRIMARY_DIV = 8'hF7;
    localparam logic [7:0] MASK_SECONDARY_DIV = 8'hF0;
    // field positions
    localparam int SYNTH_RATIO_LSB = 4;
    localparam int INPUT_RATIO_LSB = 0;
    localparam int SECOND_OUT_EN_BIT = 7;
    localparam int FIRST_OUT_EN_BIT = 6;
    localparam int FIRST_SEL_LSB = 3;
    localparam int DIV_ENABLE_BIT = 2;
    localparam int SECOND_SEL_LSB = 0;
    // divider source indices
    localparam int SRC_FIRST_SYNTH = 0;
    localparam int SRC_SECOND_SYNTH = 1;
    localparam int SRC_INPUT_CLOCK = 2;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } amc_bus_req_t;
endpackage

// ---- rtl/amc_clock_divider_mux.sv ----
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Contract
// - first synth clock divided by bits 7:4 plus one, 1 to 16
// - incoming codec master clock divided by bits 2:0 plus one, 1 to 8
// - output select: 00 first synth, x1 input clock, 10 second synth
// - secondary divider register bits 3:0 read zero, writes ignored
module amc_clock_divider_mux (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // register port
    input wire amc_pkg::amc_bus_req_t bus_req,
    output logic [7:0] bus_rdata,
    // clock sources, asynchronous to mclk
    input wire logic first_synth_clock,
    input wire logic second_synth_clock,
    input wire logic codec_master_clock_in,
    // master clock outputs
    output logic first_master_clock_out,
    output logic second_master_clock_out
);
    logic [7:0] clock_output_select_control;
    logic [7:0] primary_divider_control;
    logic [7:0] secondary_divider_control;
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] sync_c;
    logic [3:0] edge_count [3];
    logic [2:0] div_clk;

    // register decode
    wire logic hit_sel = bus_req.addr == amc_pkg::ADDR_OUT_SELECT;
    wire logic hit_pri = bus_req.addr == amc_pkg::ADDR_PRIMARY_DIV;
    wire logic hit_sec = bus_req.addr == amc_pkg::ADDR_SECONDARY_DIV;
    // registered read data is zero outside the answer cycle
    wire logic [7:0] next_rdata = !bus_req.rd ? 8'h00 :
        hit_sel ? clock_output_select_control :
        hit_pri ? primary_divider_control :
        hit_sec ? secondary_divider_control : 8'h00;

    wire logic divider_stage_enable = clock_output_select_control[amc_pkg::DIV_ENABLE_BIT];
    wire logic first_clock_out_enable = clock_output_select_control[amc_pkg::FIRST_OUT_EN_BIT];
    wire logic second_clock_out_enable = clock_output_select_control[amc_pkg::SECOND_OUT_EN_BIT];
    wire logic first_out_select_high = clock_output_select_control[amc_pkg::FIRST_SEL_LSB + 1];
    wire logic first_out_select_low = clock_output_select_control[amc_pkg::FIRST_SEL_LSB];
    wire logic second_out_select_high = clock_output_select_control[amc_pkg::SECOND_SEL_LSB + 1];
    wire logic second_out_select_low = clock_output_select_control[amc_pkg::SECOND_SEL_LSB];

    // ratio minus one per source; second synth uses the secondary register
    wire logic [3:0] synth_divide_ratio_1 = primary_divider_control[amc_pkg::SYNTH_RATIO_LSB +: 4];
    wire logic [3:0] synth_divide_ratio_2 = secondary_divider_control[amc_pkg::SYNTH_RATIO_LSB +: 4];
    wire logic [3:0] input_clock_divide_ratio = {1'b0, primary_divider_control[amc_pkg::INPUT_RATIO_LSB +: 3]};
    wire logic [3:0] ratio [3];
    assign ratio[amc_pkg::SRC_FIRST_SYNTH] = synth_divide_ratio_1;
    assign ratio[amc_pkg::SRC_SECOND_SYNTH] = synth_divide_ratio_2;
    assign ratio[amc_pkg::SRC_INPUT_CLOCK] = input_clock_divide_ratio;

    // edge on synchronised source; sync_a is read only by sync_b
    wire logic [2:0] src_edge = sync_b ^ sync_c;

    wire logic sel1 = first_out_select_low ? div_clk[amc_pkg::SRC_INPUT_CLOCK] :
        first_out_select_high ? div_clk[amc_pkg::SRC_SECOND_SYNTH] : div_clk[amc_pkg::SRC_FIRST_SYNTH];
    wire logic sel2 = second_out_select_low ? div_clk[amc_pkg::SRC_INPUT_CLOCK] :
        second_out_select_high ? div_clk[amc_pkg::SRC_SECOND_SYNTH] : div_clk[amc_pkg::SRC_FIRST_SYNTH];
    wire logic next_out1 = first_clock_out_enable & sel1;
    wire logic next_out2 = second_clock_out_enable & sel2;

    // reserved bits masked on the way in, so reads of them return zero
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            clock_output_select_control <= amc_pkg::RESET_VALUE;
            primary_divider_control <= amc_pkg::RESET_VALUE;
            secondary_divider_control <= amc_pkg::RESET_VALUE;
        end else if (bus_req.wr) begin
            if (hit_sel) begin
                clock_output_select_control <= bus_req.wdata & amc_pkg::MASK_OUT_SELECT;
            end else if (hit_pri) begin
                primary_divider_control <= bus_req.wdata & amc_pkg::MASK_PRIMARY_DIV;
            end else if (hit_sec) begin
                secondary_divider_control <= bus_req.wdata & amc_pkg::MASK_SECONDARY_DIV;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_rdata <= 8'h00;
            first_master_clock_out <= 1'b0;
            second_master_clock_out <= 1'b0;
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            sync_c <= 3'h0;
        end else begin
            bus_rdata <= next_rdata;
            first_master_clock_out <= next_out1;
            second_master_clock_out <= next_out2;
            // two flops settle the foreign clocks, a third finds the edge
            sync_a <= {codec_master_clock_in, second_synth_clock, first_synth_clock};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // both edges counted so every ratio keeps a 50 percent duty cycle
    for (genvar i = 0; i < 3; i++) begin : g_div
        always_ff @(posedge mclk or posedge reset) begin
            if (reset) begin
                edge_count[i] <= 4'h0;
                div_clk[i] <= 1'b0;
            end else if (!divider_stage_enable) begin
                edge_count[i] <= 4'h0;
                div_clk[i] <= 1'b0;
            end else if (edge_count[i] > ratio[i]) begin
                // ratio shrank under a running count: restart instead of wrapping through 15
                edge_count[i] <= 4'h0;
            end else if (src_edge[i]) begin
                if (edge_count[i] == ratio[i]) begin
                    edge_count[i] <= 4'h0;
                    div_clk[i] <= ~div_clk[i];
                end else begin
                    edge_count[i] <= edge_count[i] + 4'h1;
                end
            end
        end
    end

    // named steps for the read and select checks
    sequence sec_read_s;
        bus_req.rd && hit_sec;
    endsequence

    sequence out2_first_s;
        second_clock_out_enable && !second_out_select_high && !second_out_select_low;
    endsequence

    sequence out2_second_s;
        second_clock_out_enable && second_out_select_high && !second_out_select_low;
    endsequence

    sequence out1_input_s;
        first_clock_out_enable && first_out_select_low;
    endsequence

    sequence out1_first_s;
        first_clock_out_enable && !first_out_select_high && !first_out_select_low;
    endsequence

    synth_div_step_a: assert property (@(posedge mclk) disable iff (reset)
        $past(divider_stage_enable) && $changed(div_clk[0])
        |-> $past(edge_count[0]) == $past(synth_divide_ratio_1))
        else $error("first synth divider toggled off its ratio");
    input_div_step_a: assert property (@(posedge mclk) disable iff (reset)
        $past(divider_stage_enable) && $changed(div_clk[2])
        |-> $past(edge_count[2]) == $past(input_clock_divide_ratio))
        else $error("input clock divider toggled off its ratio");
    input_div_range_a: assert property (@(posedge mclk) disable iff (reset)
        edge_count[2] <= 4'h7)
        else $error("input clock divider count above seven");
    out_two_mux_a: assert property (@(posedge mclk) disable iff (reset)
        second_clock_out_enable && second_out_select_low |=> second_master_clock_out == $past(div_clk[2]))
        else $error("second output not following input clock divider");
    out_one_mux_a: assert property (@(posedge mclk) disable iff (reset)
        first_clock_out_enable && !first_out_select_low && first_out_select_high
        |=> first_master_clock_out == $past(div_clk[1]))
        else $error("first output not following second synth divider");
    reserved_zero_a: assert property (@(posedge mclk) disable iff (reset)
        sec_read_s |=> bus_rdata[3:0] == 4'h0)
        else $error("reserved secondary bits read nonzero");
    div_idle_a: assert property (@(posedge mclk) disable iff (reset)
        !divider_stage_enable [*2] |-> div_clk == 3'h0 && edge_count[1] == 4'h0)
        else $error("divider active while disabled");
    out_gated_a: assert property (@(posedge mclk) disable iff (reset)
        !first_clock_out_enable ##1 !$past(first_clock_out_enable) |-> !first_master_clock_out)
        else $error("first output not held low while disabled");
    out_two_gated_a: assert property (@(posedge mclk) disable iff (reset)
        !second_clock_out_enable |=> !second_master_clock_out)
        else $error("second output not held low while disabled");
    count_idle_a: assert property (@(posedge mclk) disable iff (reset)
        !divider_stage_enable [*2] |-> edge_count[0] == 4'h0 && edge_count[2] == 4'h0)
        else $error("divider count running while disabled");
    div_out_low_a: assert property (@(posedge mclk) disable iff (reset)
        !divider_stage_enable [*2] |=> !first_master_clock_out && !second_master_clock_out)
        else $error("output toggling while dividers disabled");

    // remaining output select codes
    out_two_first_a: assert property (@(posedge mclk) disable iff (reset)
        out2_first_s |=> second_master_clock_out == $past(div_clk[0]))
        else $error("second output not following first synth divider");
    out_two_second_a: assert property (@(posedge mclk) disable iff (reset)
        out2_second_s |=> second_master_clock_out == $past(div_clk[1]))
        else $error("second output not following second synth divider");
    out_one_input_a: assert property (@(posedge mclk) disable iff (reset)
        out1_input_s |=> first_master_clock_out == $past(div_clk[2]))
        else $error("first output not following input clock divider");
    out_one_first_a: assert property (@(posedge mclk) disable iff (reset)
        out1_first_s |=> first_master_clock_out == $past(div_clk[0]))
        else $error("first output not following first synth divider");

    // second synth stage toggles at its ratio; first synth and input stages toggle only on a source edge and restart a count left past a shrunk ratio
    second_div_step_a: assert property (@(posedge mclk) disable iff (reset)
        $past(divider_stage_enable) && $changed(div_clk[1])
        |-> $past(edge_count[1]) == $past(synth_divide_ratio_2))
        else $error("second synth divider toggled off its ratio");
    first_div_edge_a: assert property (@(posedge mclk) disable iff (reset)
        $past(divider_stage_enable) && $changed(div_clk[0]) |-> $past(src_edge[0]))
        else $error("first synth divider toggled without a source edge");
    input_div_edge_a: assert property (@(posedge mclk) disable iff (reset)
        $past(divider_stage_enable) && $changed(div_clk[2]) |-> $past(src_edge[2]))
        else $error("input clock divider toggled without a source edge");
    synth_guard_a: assert property (@(posedge mclk) disable iff (reset)
        edge_count[0] > synth_divide_ratio_1 |=> edge_count[0] == 4'h0)
        else $error("first synth count not restarted after ratio change");
    input_guard_a: assert property (@(posedge mclk) disable iff (reset)
        edge_count[2] > input_clock_divide_ratio |=> edge_count[2] == 4'h0)
        else $error("input clock count not restarted after ratio change");

    // register port
    secondary_low_a: assert property (@(posedge mclk) disable iff (reset)
        secondary_divider_control[3:0] == 4'h0)
        else $error("reserved secondary bits hold a written value");
    sec_read_data_a: assert property (@(posedge mclk) disable iff (reset)
        sec_read_s |=> bus_rdata[7:4] == $past(secondary_divider_control[7:4]))
        else $error("secondary divider read data lost its ratio field");
endmodule // amc_clock_divider_mux

// ---- tb/amc_codec_model.sv ----
`timescale 1ns/1ps
module amc_codec_model #(
    parameter real HALF_NS = 100.0
) (
    // received master clocks
    input wire logic first_master_clock_out,
    input wire logic second_master_clock_out,
    // codec clock and observed edges
    output logic codec_master_clock_in,
    output int first_rises,
    output int second_rises
);
    // free-running oscillator, well below mclk/2 so every edge is counted
    initial codec_master_clock_in = 1'b0;
    always #(HALF_NS) codec_master_clock_in = ~codec_master_clock_in;
    initial first_rises = 0;
    initial second_rises = 0;
    always @(posedge first_master_clock_out) first_rises++;
    always @(posedge second_master_clock_out) second_rises++;
endmodule // amc_codec_model

// ---- tb/amc_clock_divider_mux_tb.sv ----
`timescale 1ns/1ps
module amc_clock_divider_mux_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    amc_pkg::amc_bus_req_t bus_req = '0;
    logic [7:0] bus_rdata;
    logic first_synth_clock = 1'b0;
    logic second_synth_clock = 1'b0;
    logic codec_master_clock_in, first_master_clock_out, second_master_clock_out;
    int first_rises, second_rises;
    int error_cnt = 0;
    int cmp_count = 0;
    // primary, secondary, select; expected periods in ns
    logic [23:0] cfg [4] = '{24'h3010C6, 24'hF700CC, 24'h0200DF, 24'h0030D6};
    int exp1 [4] = '{480, 1600, 600, 640};
    int exp2 [4] = '{320, 1920, 600, 640};
    always #12.5 mclk = ~mclk;
    always #60 first_synth_clock = ~first_synth_clock;
    always #80 second_synth_clock = ~second_synth_clock;
    amc_clock_divider_mux amc_clock_divider_mux_i (.mclk, .reset, .bus_req, .bus_rdata, .first_synth_clock,
        .second_synth_clock, .codec_master_clock_in, .first_master_clock_out, .second_master_clock_out);
    amc_codec_model amc_codec_model_i (.first_master_clock_out, .second_master_clock_out,
        .codec_master_clock_in, .first_rises, .second_rises);
    task automatic summarize();
        if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        @(negedge mclk);
        check({24'h0, bus_rdata}, {24'h0, exp});
    endtask
    task automatic wait_rise(input logic sel);
        int c0;
        int n;
        c0 = sel ? second_rises : first_rises;
        n = 0;
        while ((sel ? second_rises : first_rises) == c0) begin
            @(posedge mclk);
            n++;
            if (n > 200) begin
                error_cnt++;
                summarize();
            end
        end
    endtask
    // one mclk of jitter from synchronising the source
    task automatic period(input logic sel, input int exp_ns);
        realtime t0;
        int d;
        wait_rise(sel);
        wait_rise(sel);
        t0 = $realtime;
        wait_rise(sel);
        d = int'($realtime - t0);
        if (d > exp_ns - 26 && d < exp_ns + 26) d = exp_ns;
        check(32'(d), 32'(exp_ns));
    endtask
    task automatic hold_low(input logic [7:0] sel);
        int n;
        wr(16'hFFE1, sel);
        repeat (2) @(posedge mclk);
        n = first_rises + second_rises;
        repeat (100) @(posedge mclk);
        check(32'(first_rises + second_rises), 32'(n));
        check({30'h0, first_master_clock_out, second_master_clock_out}, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        rd(16'hFFE1, 8'h00);
        rd(16'hFFE2, 8'h00);
        rd(16'hFFF6, 8'h00);
        wr(16'hFFE1, 8'hFF);
        wr(16'hFFE2, 8'hFF);
        wr(16'hFFF6, 8'hFF);
        rd(16'hFFE1, 8'hDF);
        rd(16'hFFE2, 8'hF7);
        rd(16'hFFF6, 8'hF0);
        rd(16'hFFE3, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(16'hFFE2, cfg[i][23:16]);
            wr(16'hFFF6, cfg[i][15:8]);
            wr(16'hFFE1, cfg[i][7:0]);
            period(1'b0, exp1[i]);
            period(1'b1, exp2[i]);
        end
        hold_low(8'h1E);
        hold_low(8'hC0);
        summarize();
    end
endmodule // amc_clock_divider_mux_tb
